/* File: hdl/sclm_pkg.sv */
package sclm_pkg;
	localparam int NPORT         = 5;
	localparam int PW            = 3;
	localparam int TBL_DEPTH     = 1024;
	localparam int TBL_AW        = 10;
	localparam int NBUF          = 512;
	localparam int BUF_BYTES     = 128;
	localparam int BUF_CW        = 10;
	localparam int SHARE_DIV     = 5;
	localparam int CLK_HZ        = 20000000;
	localparam int AGE_BASE_S    = 300;
	localparam int AGE_EXTRA_S   = 75;
	localparam int STAMP_S       = 75;
	localparam int AGE_STAMPS    = (AGE_BASE_S + AGE_EXTRA_S) / STAMP_S;
	localparam int IPG_BITS      = 96;
	localparam int SLOT_BITS     = 512;
	localparam int MAX_ATTEMPTS  = 16;
	localparam int BACKOFF_LIMIT = 10;
	localparam int MIN_LEN       = 64;
	localparam int MAX_LEN_STD   = 1536;
	localparam int MAX_LEN_HUGE  = 1916;
	localparam int VLAN_TAG_LEN  = 4;
	localparam logic [15:0] PAUSE_MAX  = 16'hffff;
	localparam logic [15:0] PAUSE_ZERO = 16'h0000;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COUNT  = 8'h08;
	localparam logic [7:0] ADDR_FREE   = 8'h0c;
	localparam int CTRL_AGE_EN   = 0;
	localparam int CTRL_SHARE    = 1;
	localparam int CTRL_AGGR     = 2;
	localparam int CTRL_NO_XDROP = 3;
	localparam int CTRL_HUGE     = 4;
	localparam int CTRL_FC_EN    = 5;
	localparam logic [7:0] CTRL_RST = 8'h21;
	localparam int HYST_BUFS     = 8;
	localparam int RXQ_DEPTH     = 64;
	typedef enum logic [1:0] {SCLM_RES_FWD, SCLM_RES_DROP_ERR,
		SCLM_RES_DROP_PAUSE, SCLM_RES_DROP_LOCAL} sclm_res_t;
endpackage

/* File: hdl/sclm_core.sv */
// What this block does
// RULE1 - Table holds 1K addresses, fully associative
// RULE2 - Learn new source with port, stamp
// RULE3 - Full table drops last entry first
// RULE4 - Moved station gets new port
// RULE5 - Refresh stamp, age out after 375s; code ages out 4 stamps (225 to 300s) after last refresh
// RULE6 - Two-stage egress set resolution
// RULE7 - Never forward errored or mis-sized frames
// RULE8 - Pause frames consumed, not forwarded
// RULE9 - Same-port destination is local, dropped
// RULE10 - Store whole frame before forwarding
// RULE11 - 512 shared buffers, optional fifth limit
// RULE12 - 96-bit gap between transmit enables
// RULE13 - Standard or aggressive backoff
// RULE14 - Sixteenth collision drops or retries
// RULE15 - Late collision drops frame
// RULE16 - Drop short, limit long frames
// RULE17 - Tagged frames get extra length
// RULE18 - Pause holds frames, reloads timer
// RULE19 - Only own flow frames while paused
// RULE20 - Exhausted destination sends max pause
// RULE21 - Freed resources send zero pause
// RULE22 - Full receive queue pauses all
`timescale 1ns/1ps
module sclm_core
	import sclm_pkg::*;
#(
	parameter int AGE_TICK_CYC = 75 * sclm_pkg::CLK_HZ,
	parameter int BIT_CYC      = 1
) (
	input  wire logic                          clk_sys,
	input  wire logic                          nrst,
	input  wire logic                          strap_age_en,
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic [31:0]                        reg_rdata,
	input  wire logic                          rx_done,
	input  wire logic [sclm_pkg::PW-1:0]       rx_port,
	input  wire logic [47:0]                   rx_sa,
	input  wire logic [47:0]                   rx_da,
	input  wire logic [10:0]                   rx_len,
	input  wire logic                          rx_err,
	input  wire logic                          rx_tagged,
	input  wire logic                          rx_pause,
	input  wire logic [15:0]                   rx_pause_time,
	input  wire logic [11:0]                   rx_vid,
	input  wire logic [sclm_pkg::NPORT-1:0]    static_mask,
	input  wire logic [sclm_pkg::NPORT-1:0]    vlan_mask,
	input  wire logic [sclm_pkg::NPORT-1:0]    stp_fwd_mask,
	input  wire logic [sclm_pkg::NPORT-1:0]    igmp_mask,
	input  wire logic [sclm_pkg::NPORT-1:0]    mirror_mask,
	input  wire logic                          rxq_full,
	output logic                               fwd_valid,
	output logic [sclm_pkg::NPORT-1:0]         final_egress_port_set,
	output sclm_pkg::sclm_res_t                fwd_result,
	input  wire logic [sclm_pkg::NPORT-1:0]    buf_release,
	input  wire logic [sclm_pkg::NPORT-1:0]    tx_req,
	input  wire logic [sclm_pkg::NPORT-1:0]    tx_busy,
	input  wire logic [sclm_pkg::NPORT-1:0]    tx_col,
	input  wire logic [sclm_pkg::NPORT-1:0]    tx_crs,
	output logic [sclm_pkg::NPORT-1:0]         tx_grant,
	output logic [sclm_pkg::NPORT-1:0]         tx_drop,
	output logic [sclm_pkg::NPORT-1:0]         fc_send,
	output logic [15:0]                        fc_time
);
	import sclm_pkg::*;

	localparam int SLOT_CYC = SLOT_BITS * BIT_CYC;
	localparam int IPG_CYC  = IPG_BITS * BIT_CYC;
	localparam int PORT_SHARE = NBUF / SHARE_DIV;
	// Wide stamps keep a stale entry from wrapping back to young between scans
	localparam int STAMP_W    = 8;

	logic [7:0]          ctrl_ff;
	logic                strap_done_ff;
	logic [47:0]         mac_ff   [TBL_DEPTH];
	logic [PW-1:0]       port_ff  [TBL_DEPTH];
	logic [STAMP_W-1:0]  stamp_ff [TBL_DEPTH];
	logic [TBL_DEPTH-1:0] vld_ff;
	logic [TBL_AW:0]     count_ff;
	logic [STAMP_W-1:0]  now_ff;
	logic [31:0]         tick_ff;
	logic [TBL_AW-1:0]   age_ptr_ff;
	logic [BUF_CW-1:0]   used_ff [NPORT];
	logic [BUF_CW-1:0]   total_ff;
	logic [NPORT-1:0]    xoff_ff;
	logic [NPORT-1:0]    rxq_xoff_ff;

	// Strap caught after reset release
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			strap_done_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_done_ff <= 1'b1;
		end
	end

	// Register port
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_ff <= CTRL_RST;
		end else if (!strap_done_ff) begin
			// RULE5 strap sets aging
			ctrl_ff[CTRL_AGE_EN] <= strap_age_en;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			ctrl_ff <= reg_wdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_CTRL:   reg_rdata <= {24'h000000, ctrl_ff};
				ADDR_STATUS: reg_rdata <= {22'h000000, rxq_xoff_ff, xoff_ff};
				ADDR_COUNT:  reg_rdata <= {21'h000000, count_ff};
				ADDR_FREE:   reg_rdata <= 32'(NBUF) - {22'h000000, total_ff};
				default:     reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// RULE1 associative search, no hashing
	logic              sa_hit;
	logic [TBL_AW-1:0] sa_idx;
	logic              da_hit;
	logic [TBL_AW-1:0] da_idx;
	logic              free_hit;
	logic [TBL_AW-1:0] free_idx;
	always_comb begin
		sa_hit = 1'b0;
		sa_idx = '0;
		da_hit = 1'b0;
		da_idx = '0;
		free_hit = 1'b0;
		free_idx = '0;
		for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
			if (vld_ff[i] && mac_ff[i] == rx_sa) begin
				sa_hit = 1'b1;
				sa_idx = TBL_AW'(i);
			end
			if (vld_ff[i] && mac_ff[i] == rx_da) begin
				da_hit = 1'b1;
				da_idx = TBL_AW'(i);
			end
			if (!vld_ff[i]) begin
				free_hit = 1'b1;
				free_idx = TBL_AW'(i);
			end
		end
	end

	// RULE16 length window, RULE17 tag allowance
	logic [11:0] max_len;
	logic        good;
	always_comb begin
		max_len = ctrl_ff[CTRL_HUGE] ? 12'(MAX_LEN_HUGE) : 12'(MAX_LEN_STD);
		if (rx_tagged) begin
			max_len = max_len + 12'(VLAN_TAG_LEN);
		end
		good = !rx_err && ({1'b0, rx_len} >= 12'(MIN_LEN)) && ({1'b0, rx_len} <= max_len);
	end

	// Aging time base
	logic age_tick;
	assign age_tick = (tick_ff == 32'(AGE_TICK_CYC - 1));
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tick_ff <= 32'h0000_0000;
			now_ff  <= '0;
		end else if (age_tick) begin
			tick_ff <= 32'h0000_0000;
			now_ff  <= now_ff + STAMP_W'(1);
		end else begin
			tick_ff <= tick_ff + 32'h0000_0001;
		end
	end

	logic              learn_we;
	logic [TBL_AW-1:0] learn_idx;
	logic              age_kill;
	logic [STAMP_W-1:0] age_diff;
	assign learn_we  = rx_done && good && !rx_pause;
	// RULE3 full table reuses last entry
	assign learn_idx = sa_hit ? sa_idx : (free_hit ? free_idx : TBL_AW'(TBL_DEPTH - 1));
	assign age_diff  = now_ff - stamp_ff[age_ptr_ff];
	// RULE5 age scan removes stale entries
	assign age_kill  = ctrl_ff[CTRL_AGE_EN] && vld_ff[age_ptr_ff] &&
		(age_diff >= STAMP_W'(AGE_STAMPS - 1)) && !(learn_we && learn_idx == age_ptr_ff);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			vld_ff     <= '0;
			count_ff   <= '0;
			age_ptr_ff <= '0;
		end else begin
			age_ptr_ff <= age_ptr_ff + TBL_AW'(1);
			if (age_kill) begin
				vld_ff[age_ptr_ff] <= 1'b0;
			end
			if (learn_we && !sa_hit) begin
				// RULE2 learn new entry
				vld_ff[learn_idx] <= 1'b1;
			end
			if (learn_we && !sa_hit && free_hit && !age_kill) begin
				count_ff <= count_ff + (TBL_AW+1)'(1);
			end else if (age_kill && !(learn_we && !sa_hit && free_hit)) begin
				count_ff <= count_ff - (TBL_AW+1)'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (learn_we) begin
			mac_ff[learn_idx]   <= rx_sa;
			// RULE4 migration rewrites port
			port_ff[learn_idx]  <= rx_port;
			// RULE5 stamp refresh
			stamp_ff[learn_idx] <= now_ff;
		end
	end

	// RULE6 stage one then stage two
	logic [NPORT-1:0] initial_egress_port_set;
	logic [NPORT-1:0] stage2;
	logic [NPORT-1:0] src_bit;
	sclm_res_t        res;
	always_comb begin
		src_bit = NPORT'(1) << rx_port;
		if (|static_mask) begin
			initial_egress_port_set = static_mask & vlan_mask;
		end else if (da_hit) begin
			initial_egress_port_set = (NPORT'(1) << port_ff[da_idx]) & vlan_mask;
		end else begin
			initial_egress_port_set = vlan_mask;
		end
		stage2 = ((initial_egress_port_set & stp_fwd_mask & igmp_mask) | mirror_mask)
			& vlan_mask & ~src_bit;
		res = SCLM_RES_FWD;
		if (!good) begin
			// RULE7 errored frames dropped
			res = SCLM_RES_DROP_ERR;
		end else if (rx_pause) begin
			// RULE8 pause consumed
			res = SCLM_RES_DROP_PAUSE;
		end else if (da_hit && port_ff[da_idx] == rx_port && ~|static_mask) begin
			// RULE9 local frame dropped
			res = SCLM_RES_DROP_LOCAL;
		end
	end

	// RULE10 forward only at frame end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fwd_valid             <= 1'b0;
			final_egress_port_set <= '0;
			fwd_result            <= SCLM_RES_FWD;
		end else begin
			fwd_valid             <= rx_done;
			fwd_result            <= res;
			final_egress_port_set <= (rx_done && res == SCLM_RES_FWD) ? stage2 : '0;
		end
	end

	// RULE11 buffer accounting per port
	logic [BUF_CW-1:0] frame_bufs;
	logic              admit;
	assign frame_bufs = BUF_CW'((rx_len + 11'(BUF_BYTES - 1)) / 11'(BUF_BYTES));
	assign admit = ({1'b0, total_ff} + {1'b0, frame_bufs} <= (BUF_CW+1)'(NBUF)) &&
		(!ctrl_ff[CTRL_SHARE] || (used_ff[rx_port] + frame_bufs <= BUF_CW'(PORT_SHARE)));

	logic [BUF_CW-1:0] rel_sum;
	always_comb begin
		rel_sum = '0;
		for (int p = 0; p < NPORT; p++) begin
			if (buf_release[p]) begin
				rel_sum = rel_sum + used_ff[p];
			end
		end
	end

	logic take;
	assign take = rx_done && res == SCLM_RES_FWD && admit;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			total_ff <= '0;
			for (int p = 0; p < NPORT; p++) begin
				used_ff[p] <= '0;
			end
		end else begin
			total_ff <= total_ff - rel_sum + (take ? frame_bufs : BUF_CW'(0));
			for (int p = 0; p < NPORT; p++) begin
				if (buf_release[p]) begin
					used_ff[p] <= '0;
				end else if (take && rx_port == PW'(p)) begin
					used_ff[p] <= used_ff[p] + frame_bufs;
				end
			end
		end
	end

	// RULE20 exhaustion sets XOFF, RULE21 hysteresis XON
	logic [NPORT-1:0] nxt_xoff;
	logic             low_water;
	assign low_water = (32'(total_ff) + 32'(HYST_BUFS) < 32'(NBUF));
	always_comb begin
		nxt_xoff = xoff_ff;
		for (int p = 0; p < NPORT; p++) begin
			if (xoff_ff[p] && low_water && !rxq_full) begin
				nxt_xoff[p] = 1'b0;
			end
			if (ctrl_ff[CTRL_FC_EN] && rx_done && good && !rx_pause && !admit &&
				rx_port == PW'(p)) begin
				nxt_xoff[p] = 1'b1;
			end
			// RULE22 full receive queue pauses all
			if (ctrl_ff[CTRL_FC_EN] && rxq_full) begin
				nxt_xoff[p] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			xoff_ff     <= '0;
			rxq_xoff_ff <= '0;
			fc_send     <= '0;
			fc_time     <= PAUSE_ZERO;
		end else begin
			xoff_ff     <= nxt_xoff;
			rxq_xoff_ff <= {NPORT{rxq_full}};
			fc_send     <= nxt_xoff ^ xoff_ff;
			fc_time     <= (|(nxt_xoff & ~xoff_ff)) ? PAUSE_MAX : PAUSE_ZERO;
		end
	end

	// Per-port MAC transmit control
	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_mac
			logic [31:0] pause_ff;
			logic [15:0] gap_ff;
			logic [15:0] txc_ff;
			logic [4:0]  att_ff;
			logic [31:0] bo_ff;
			logic [15:0] lfsr_ff;
			logic        busy_d_ff;
			logic        col_d_ff;
			logic        crs_d_ff;
			logic        fresh_col;
			logic [3:0]  k;
			assign fresh_col = tx_col[g] && !col_d_ff;
			// Backoff range stops growing at 2^10 slots
			assign k = (att_ff >= 5'(BACKOFF_LIMIT)) ? 4'(BACKOFF_LIMIT - 1) : att_ff[3:0];

			// RULE18 pause timer load and reload
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					pause_ff <= 32'h0000_0000;
				end else if (rx_done && rx_pause && good && rx_port == PW'(g)) begin
					pause_ff <= {16'h0000, rx_pause_time} * 32'(SLOT_CYC);
				end else if (pause_ff != 32'h0000_0000) begin
					pause_ff <= pause_ff - 32'h0000_0001;
				end
			end

			// RULE12 gap from enable or carrier
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					gap_ff    <= 16'h0000;
					busy_d_ff <= 1'b0;
					col_d_ff  <= 1'b0;
					crs_d_ff  <= 1'b0;
				end else begin
					busy_d_ff <= tx_busy[g];
					col_d_ff  <= tx_col[g];
					crs_d_ff  <= tx_crs[g];
					if ((tx_busy[g] && !busy_d_ff) || (crs_d_ff && !tx_crs[g])) begin
						gap_ff <= 16'(IPG_CYC);
					end else if (tx_crs[g]) begin
						gap_ff <= 16'(IPG_CYC);
					end else if (gap_ff != 16'h0000) begin
						gap_ff <= gap_ff - 16'h0001;
					end
				end
			end

			// RULE13 backoff, RULE14 attempt limit, RULE15 late collision
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					txc_ff     <= 16'h0000;
					att_ff     <= 5'h00;
					bo_ff      <= 32'h0000_0000;
					lfsr_ff    <= 16'h0001;
					tx_drop[g] <= 1'b0;
				end else begin
					lfsr_ff    <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
					tx_drop[g] <= 1'b0;
					txc_ff     <= tx_busy[g] ? txc_ff + 16'h0001 : 16'h0000;
					if (bo_ff != 32'h0000_0000) begin
						bo_ff <= bo_ff - 32'h0000_0001;
					end
					if (fresh_col && tx_busy[g]) begin
						if (txc_ff >= 16'(SLOT_CYC)) begin
							tx_drop[g] <= 1'b1;
							att_ff     <= 5'h00;
						end else if (att_ff == 5'(MAX_ATTEMPTS - 1)) begin
							tx_drop[g] <= !ctrl_ff[CTRL_NO_XDROP];
							att_ff     <= 5'h00;
						end else begin
							att_ff <= att_ff + 5'h01;
							bo_ff  <= ctrl_ff[CTRL_AGGR] ? 32'h0000_0000 :
								(32'(lfsr_ff) & ((32'h1 << (k + 4'h1)) - 32'h1)) * 32'(SLOT_CYC);
						end
					end else if (busy_d_ff && !tx_busy[g] && !col_d_ff) begin
						att_ff <= 5'h00;
					end
				end
			end

			// RULE19 normal frames held while paused
			assign tx_grant[g] = tx_req[g] && !tx_busy[g] && gap_ff == 16'h0000 &&
				bo_ff == 32'h0000_0000 && pause_ff == 32'h0000_0000 && !fc_send[g];
		end
	endgenerate
endmodule

/* File: sim/sclm_link_partner.sv */
`timescale 1ns/1ps
module sclm_link_partner (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        want,
	input  wire logic [11:0] col_at,
	input  wire logic        grant,
	output logic             tx_req,
	output logic             tx_busy,
	output logic             tx_col,
	output logic             tx_crs
);
	logic [11:0] cnt_ff;

	// Asks only while idle, so a grant always starts a fresh frame
	assign tx_req = want & ~tx_busy;
	assign tx_crs = tx_busy;
	assign tx_col = tx_busy && (col_at != 12'h000) && (cnt_ff == col_at);

	// Frame of 641 bit times; a collision ends it early
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tx_busy <= 1'b0;
			cnt_ff  <= 12'h000;
		end else if (grant) begin
			tx_busy <= 1'b1;
			cnt_ff  <= 12'h000;
		end else if (tx_busy) begin
			cnt_ff  <= cnt_ff + 12'h001;
			tx_busy <= !(tx_col || cnt_ff == 12'h280);
		end
	end
endmodule

/* File: sim/sclm_core_sva.sv */
`timescale 1ns/1ps
module sclm_core_chk
	import sclm_pkg::*;
(
	input wire logic                clk_sys,
	input wire logic                nrst,
	input wire logic                reg_rd,
	input wire logic [31:0]         reg_rdata,
	input wire logic                rx_done,
	input wire logic [2:0]          rx_port,
	input wire logic [10:0]         rx_len,
	input wire logic                rx_err,
	input wire logic                rx_pause,
	input wire logic                fwd_valid,
	input wire logic [4:0]          final_egress_port_set,
	input wire sclm_pkg::sclm_res_t fwd_result,
	input wire logic [4:0]          tx_req,
	input wire logic [4:0]          tx_busy,
	input wire logic [4:0]          tx_col,
	input wire logic [4:0]          tx_crs,
	input wire logic [4:0]          tx_grant,
	input wire logic [4:0]          tx_drop,
	input wire logic [4:0]          fc_send
);
	import sclm_pkg::*;
	logic [10:0] bcnt_ff;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bcnt_ff <= 11'h000;
		end else begin
			bcnt_ff <= tx_busy[4] ? bcnt_ff + 11'h001 : 11'h000;
		end
	end

	sequence s_bad;
		rx_done && (rx_err || rx_len < 11'h040);
	endsequence
	sequence s_pause_in;
		rx_done && rx_pause && !rx_err && rx_len >= 11'h040 && rx_len <= 11'h600;
	endsequence
	sequence s_quiet0;
		!tx_grant[0] [*8];
	endsequence

	a_fwd_follows: assert property (rx_done |=> fwd_valid)
		else $error("no forward answer after frame end");
	a_no_spur_fwd: assert property (!rx_done |=> !fwd_valid)
		else $error("forward answer without frame");
	a_err_dropped: assert property (s_bad |=> fwd_result == SCLM_RES_DROP_ERR &&
		final_egress_port_set == 5'h00) else $error("bad frame forwarded");
	a_pause_eaten: assert property (s_pause_in |=> fwd_result == SCLM_RES_DROP_PAUSE &&
		final_egress_port_set == 5'h00) else $error("pause frame forwarded");
	a_src_excluded: assert property (rx_done |=> !final_egress_port_set[$past(rx_port)])
		else $error("frame sent back to ingress port");
	a_rd_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read answer");
	a_grant_qual: assert property ((tx_grant & (~tx_req | tx_busy | fc_send)) == 5'h00)
		else $error("grant without request or during flow frame");
	a_gap_hold: assert property ($fell(tx_crs[0]) |-> s_quiet0)
		else $error("grant inside inter packet gap");
	a_late_drop: assert property (tx_col[4] && bcnt_ff > 11'h208 |-> ##[0:8] tx_drop[4])
		else $error("late collision not dropped");
endmodule

bind sclm_core sclm_core_chk i_sclm_core_chk (.clk_sys, .nrst, .reg_rd, .reg_rdata, .rx_done,
	.rx_port, .rx_len, .rx_err, .rx_pause, .fwd_valid, .final_egress_port_set, .fwd_result,
	.tx_req, .tx_busy, .tx_col, .tx_crs, .tx_grant, .tx_drop, .fc_send);

/* File: sim/switch_core_lookup_mac_tb.sv */
`timescale 1ns/1ps
module switch_core_lookup_mac_tb;
	import sclm_pkg::*;
	logic clk_sys = 0, nrst = 0, strap_age_en = 1, reg_wr = 0, reg_rd = 0, rx_done = 0;
	logic rx_err = 0, rx_tagged = 0, rx_pause = 0, rxq_full = 0, fwd_valid;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, rdv;
	logic [2:0] rx_port = 0;
	logic [47:0] rx_sa = 0, rx_da = 0;
	logic [10:0] rx_len = 0;
	logic [4:0] static_mask = 0, vlan_mask = 5'h1f, stp_fwd_mask = 5'h1f, igmp_mask = 5'h1f;
	logic [4:0] mirror_mask = 0, buf_release = 0, rel = 5'h1f, want = 0, gs;
	logic [4:0] final_egress_port_set, tx_req, tx_busy, tx_col, tx_crs, tx_grant, tx_drop, fc_send;
	logic [11:0] col_at [5] = '{default: 0};
	logic [15:0] fc_time, pause_t = 16'h0001;
	sclm_res_t fwd_result, gr;
	int errors = 0, comparisons = 0, cyc = 0, p, q, g;
	int gcnt [5] = '{default: 0}, dcnt [5] = '{default: 0};
	int ocnt [5] = '{default: 0}, ncnt [5] = '{default: 0}, snap [5];
	int lens [8] = '{63, 64, 1536, 1537, 1540, 1541, 1916, 1917};

	sclm_core #(.AGE_TICK_CYC(100), .BIT_CYC(1)) i_sclm_core (.clk_sys, .nrst, .strap_age_en,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_done, .rx_port, .rx_sa, .rx_da,
		.rx_len, .rx_err, .rx_tagged, .rx_pause, .rx_pause_time(pause_t), .rx_vid(12'h000),
		.static_mask, .vlan_mask, .stp_fwd_mask, .igmp_mask, .mirror_mask, .rxq_full, .fwd_valid,
		.final_egress_port_set, .fwd_result, .buf_release, .tx_req, .tx_busy, .tx_col, .tx_crs,
		.tx_grant, .tx_drop, .fc_send, .fc_time);
	for (genvar i = 0; i < 5; i++) begin : g_lp
		sclm_link_partner i_sclm_link_partner (.clk_sys, .nrst, .want(want[i]), .col_at(col_at[i]),
			.grant(tx_grant[i]), .tx_req(tx_req[i]), .tx_busy(tx_busy[i]), .tx_col(tx_col[i]),
			.tx_crs(tx_crs[i]));
	end

	initial begin
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chr(input sclm_res_t e);
		chk({30'h0, gr}, {30'h0, e});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 rdv = reg_rdata;
	endtask

	task automatic frame(input int pt, input logic [47:0] sa, da, input int len,
		input logic e, tg, ps);
		@(posedge clk_sys);
		rx_done <= 1;
		rx_port <= pt[2:0];
		rx_sa <= sa;
		rx_da <= da;
		rx_len <= len[10:0];
		rx_err <= e;
		rx_tagged <= tg;
		rx_pause <= ps;
		@(posedge clk_sys);
		rx_done <= 0;
		buf_release <= rel;
		#1 gs = final_egress_port_set;
		gr = fwd_result;
		@(posedge clk_sys);
		buf_release <= 0;
	endtask

	function automatic logic [4:0] exp_set(input int src, input logic hit, input int hp);
		logic [4:0] s1;
		s1 = static_mask != 0 ? static_mask & vlan_mask : hit ? 5'h01 << hp & vlan_mask : vlan_mask;
		return ((s1 & stp_fwd_mask & igmp_mask) | mirror_mask) & vlan_mask & ~(5'h01 << src);
	endfunction

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
		for (int i = 0; i < 5; i++) begin
			gcnt[i] += tx_grant[i] === 1'b1;
			dcnt[i] += tx_drop[i] === 1'b1;
			ocnt[i] += fc_send[i] === 1'b1 && fc_time === PAUSE_MAX;
			ncnt[i] += fc_send[i] === 1'b1 && fc_time === PAUSE_ZERO;
		end
	end

	initial begin
		void'($urandom(60449));
		repeat (4) @(posedge clk_sys);
		nrst <= 1;
		repeat (3) @(posedge clk_sys);
		rd(ADDR_CTRL);
		chk(rdv, 32'h21);
		rd(ADDR_FREE);
		chk(rdv, 32'h200);
		rd(8'h40);
		chk(rdv, 32'h0);
		$display("registers done");
		frame(1, 48'h0a1, 48'h0ff, 100, 0, 0, 0);
		chk(gs, exp_set(1, 0, 0));
		frame(2, 48'h0a2, 48'h0a1, 100, 0, 0, 0);
		chk(gs, exp_set(2, 1, 1));
		frame(3, 48'h0a3, 48'h0a2, 100, 1, 0, 0);
		chr(SCLM_RES_DROP_ERR);
		rd(ADDR_COUNT);
		chk(rdv, 32'h2);
		frame(3, 48'h0a1, 48'h0a2, 100, 0, 0, 0);
		frame(2, 48'h0a2, 48'h0a1, 100, 0, 0, 0);
		chk(gs, exp_set(2, 1, 3));
		frame(3, 48'h0a3, 48'h0a1, 100, 0, 0, 0);
		chr(SCLM_RES_DROP_LOCAL);
		chk(gs, 5'h00);
		$display("learning done");
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CTRL, i > 5 ? 32'h31 : 32'h21);
			frame(0, 48'h0a0, 48'h0a2, lens[i], 0, (8'h30 >> i) & 1, 0);
			chk(gs, (8'ha9 >> i) & 1 ? 5'h00 : 5'h04);
		end
		$display("sizes done");
		wr(ADDR_CTRL, 32'h20);
		for (int i = 0; i < 1030; i++) begin
			static_mask <= 5'($urandom % 31 + 1);
			vlan_mask <= 5'($urandom);
			stp_fwd_mask <= 5'($urandom);
			mirror_mask <= 5'($urandom);
			p = $urandom % 5;
			frame(p, {16'h0b00, 32'(i)}, 48'h0c7, 64 + $urandom % 1473, 0, 0, 0);
			chk(gs, exp_set(p, 0, 0));
		end
		static_mask <= 0;
		vlan_mask <= 5'h1f;
		stp_fwd_mask <= 5'h1f;
		mirror_mask <= 0;
		q = (p + 1) % 5;
		frame(q, 48'h0d0, {16'h0b00, 32'd1029}, 100, 0, 0, 0);
		chk(gs, exp_set(q, 1, p));
		rd(ADDR_COUNT);
		chk(rdv, 32'h400);
		wr(ADDR_CTRL, 32'h21);
		repeat (2000) @(posedge clk_sys);
		rd(ADDR_COUNT);
		chk(rdv, 32'h0);
		$display("table done");
		frame(0, 48'h0e0, 48'h0ff, 64, 0, 0, 1);
		chr(SCLM_RES_DROP_PAUSE);
		want[0] <= 1;
		g = gcnt[0];
		repeat (400) @(posedge clk_sys);
		chk(gcnt[0] - g, 0);
		// A second pause before expiry must restart the timer
		pause_t <= 16'h0002;
		frame(0, 48'h0e0, 48'h0ff, 64, 0, 0, 1);
		repeat (800) @(posedge clk_sys);
		chk(gcnt[0] - g, 0);
		repeat (300) @(posedge clk_sys);
		chk(gcnt[0] > g, 1);
		want <= 5'h18;
		col_at[4] <= 12'h258;
		repeat (1500) @(posedge clk_sys);
		chk(dcnt[4] > 0, 1);
		chk(dcnt[3], 0);
		// Port 3 collides early on every attempt under aggressive backoff
		wr(ADDR_CTRL, 32'h24);
		col_at[3] <= 12'h008;
		want <= 5'h08;
		g = dcnt[3];
		p = gcnt[3];
		repeat (3000) @(posedge clk_sys);
		chk(gcnt[3] - p >= 16, 1);
		chk(dcnt[3] > g, 1);
		wr(ADDR_CTRL, 32'h2c);
		repeat (2) @(posedge clk_sys);
		g = dcnt[3];
		repeat (2000) @(posedge clk_sys);
		chk(dcnt[3] - g, 0);
		col_at[3] <= 12'h000;
		want <= 0;
		$display("mac done");
		rel <= 0;
		// Share mode: one port may hold only a fifth of the pool
		wr(ADDR_CTRL, 32'h02);
		for (int i = 0; i < 9; i++) frame(2, 48'h0f2, 48'h0ff, 1536, 0, 0, 0);
		rd(ADDR_FREE);
		chk(rdv, 32'h1a0);
		buf_release <= 5'h1f;
		@(posedge clk_sys);
		buf_release <= 0;
		wr(ADDR_CTRL, 32'h21);
		g = ocnt[1];
		for (int i = 0; i < 60 && ocnt[1] == g; i++) frame(1, 48'h0f1, 48'h0ff, 1536, 0, 0, 0);
		chk(ocnt[1] > g, 1);
		g = ncnt[1];
		buf_release <= 5'h1f;
		@(posedge clk_sys);
		buf_release <= 0;
		repeat (10) @(posedge clk_sys);
		chk(ncnt[1] > g, 1);
		snap = ocnt;
		rxq_full <= 1;
		repeat (5) @(posedge clk_sys);
		for (int i = 0; i < 5; i++) chk(ocnt[i] > snap[i], 1);
		rd(ADDR_STATUS);
		chk(rdv, 32'h3ff);
		rxq_full <= 0;
		$display("flow control done");
		final_report();
	end
endmodule
